//--- rtl/icfg_bank.sv
// isa configuration bank behind the index and data port pair
`timescale 1ns/10ps
module icfg_bank
    import icfg_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [15:0] IO_ADDR,
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic [7:0] IO_WDATA,
    output logic [7:0] IO_RDATA,
    input wire logic [15:1] IRQ_IN,
    input wire logic NMI_IN,
    input wire logic GENERAL_PIN_ZERO,
    input wire logic SYS_STANDBY,
    input wire logic MON_STANDBY,
    output logic [1:0] ISA_CLK_SEL,
    output logic CMOS_UPPER_EN,
    output logic FLASH_WRITE_OK,
    output logic [3:0] REC16_CLKS,
    output logic [3:0] REC8_CLKS,
    output logic WAIT16_ZERO,
    output logic PCI_BUF_HIGH,
    output logic [7:0] TRIG_MODE_HIGH,
    output logic SYS_WAKE,
    output logic MON_WAKE
);

    icfg_state_type st;
    icfg_state_type next_st;

    function automatic logic [3:0] rec16_cycles(input logic [1:0] code);
        logic [3:0] r;
        unique case (code)
            2'h0: r = REC16_CODE0;
            2'h1: r = REC16_CODE1;
            2'h2: r = REC16_CODE2;
            2'h3: r = REC16_CODE3;
        endcase
        return r;
    endfunction : rec16_cycles

    function automatic logic [3:0] rec8_cycles(input logic [1:0] code);
        logic [3:0] r;
        unique case (code)
            2'h0: r = REC8_CODE0;
            2'h1: r = REC8_CODE1;
            2'h2: r = REC8_CODE2;
            2'h3: r = REC8_CODE3;
        endcase
        return r;
    endfunction : rec8_cycles

    // masked write: only writable bits change
    function automatic logic [7:0] wmask(input logic [7:0] d,
                                         input logic [7:0] m);
        return d & m;
    endfunction : wmask

    logic [SRC_W-1:0] src;
    logic [SRC_W-1:0] event_rise;
    logic [SRC_W-1:0] sys_mask;
    logic [SRC_W-1:0] mon_mask;
    logic [7:0] data_rd;
    logic data_wr;

    assign src = {IRQ_IN, GENERAL_PIN_ZERO, NMI_IN};

    always_comb begin
        next_st = st;
        data_wr = IO_WR && (IO_ADDR == DATA_PORT);

        // pin inputs: three flops, a change counts once stages two and
        // three agree
        next_st.sync1 = src;
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        for (int i = 0; i < SRC_W; i++) begin
            if (st.sync2[i] == st.sync3[i]) begin
                next_st.stable[i] = st.sync3[i];
            end
        end
        event_rise = next_st.stable & ~st.stable;

        // irq2 is the cascade and has no system-standby mask; it never ends system standby
        sys_mask = {st.sys_hi, st.sys_lo[7:3], 1'b1, st.sys_lo[1],
                    st.sys_lo[FLASH_OVR_BIT], st.sys_lo[0]};
        // the general pin has no monitor-standby mask and never wakes it
        mon_mask = {st.mon_hi, st.mon_lo[7:1], 1'b1, st.mon_lo[0]};

        next_st.out.sys_wake = SYS_STANDBY
            && (|(event_rise & ~sys_mask));
        next_st.out.mon_wake = MON_STANDBY
            && (|(event_rise & ~mon_mask));

        // data port read mux over the indexed bank
        unique case (st.index)
            IDX_CLK_FLASH: data_rd = st.clk_flash;
            IDX_RECOVERY: data_rd = st.recovery;
            IDX_BUF_CUR: data_rd = st.buf_cur;
            IDX_SCRATCH: data_rd = st.scratch;
            IDX_CMOS_MIRROR: data_rd = st.cmos_mirror;
            IDX_SYS_LO: data_rd = st.sys_lo;
            IDX_SYS_HI: data_rd = st.sys_hi;
            IDX_MON_LO: data_rd = st.mon_lo;
            IDX_MON_HI: data_rd = st.mon_hi;
            default: data_rd = 8'h00;
        endcase

        // writes
        if (IO_WR) begin
            unique case (IO_ADDR)
                IDX_PORT: next_st.index = IO_WDATA;
                CMOS_PORT: next_st.cmos_mirror = IO_WDATA;
                TRIG_PORT: begin
                    next_st.out.trig = wmask(IO_WDATA, WMASK_TRIG);
                end
                default: ;
            endcase
        end
        if (data_wr) begin
            unique case (st.index)
                IDX_CLK_FLASH: begin
                    next_st.clk_flash = wmask(IO_WDATA, WMASK_CLK_FLASH);
                end
                IDX_RECOVERY: begin
                    next_st.recovery = wmask(IO_WDATA, WMASK_RECOVERY);
                end
                IDX_BUF_CUR: begin
                    next_st.buf_cur = wmask(IO_WDATA, WMASK_BUF_CUR);
                end
                IDX_SCRATCH: next_st.scratch = IO_WDATA;
                IDX_SYS_LO: next_st.sys_lo = IO_WDATA;
                IDX_SYS_HI: next_st.sys_hi = IO_WDATA;
                IDX_MON_LO: next_st.mon_lo = IO_WDATA;
                IDX_MON_HI: next_st.mon_hi = IO_WDATA;
                default: ;
            endcase
        end

        // reads: answer registered one cycle after the strobe
        next_st.out.rdata = 8'h00;
        if (IO_RD) begin
            unique case (IO_ADDR)
                IDX_PORT: next_st.out.rdata = st.index;
                DATA_PORT: next_st.out.rdata = data_rd;
                TRIG_PORT: next_st.out.rdata = st.out.trig;
                default: next_st.out.rdata = 8'h00;
            endcase
        end

        // decoded controls follow the stored fields
        next_st.out.clk_sel =
            next_st.clk_flash[CLK_SEL_LSB +: 2];
        next_st.out.cmos_upper_en =
            next_st.clk_flash[CMOS_UPPER_BIT];
        next_st.out.flash_ok = !next_st.clk_flash[FLASH_LOCK_BIT]
            || next_st.clk_flash[FLASH_OVR_BIT];
        next_st.out.rec16 =
            rec16_cycles(next_st.recovery[REC16_LSB +: 2]);
        next_st.out.rec8 =
            rec8_cycles(next_st.recovery[REC8_LSB +: 2]);
        next_st.out.wait16_zero =
            next_st.recovery[WAIT16_BIT];
        next_st.out.buf_high = next_st.buf_cur[BUF_CUR_BIT];
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            st <= '0;
            st.index <= RST_INDEX;
            st.clk_flash <= RST_CFG;
            st.recovery <= RST_CFG;
            st.buf_cur <= RST_CFG;
            st.scratch <= RST_CFG;
            st.cmos_mirror <= RST_CFG;
            st.sys_lo <= RST_CFG;
            st.sys_hi <= RST_CFG;
            st.mon_lo <= RST_CFG;
            st.mon_hi <= RST_CFG;
            st.out.trig <= RST_TRIG;
            st.out.clk_sel <= CLK_SEL_OSC;
            st.out.flash_ok <= 1'b1;
            st.out.rec16 <= REC16_CODE0;
            st.out.rec8 <= REC8_CODE0;
        end else begin
            st <= next_st;
        end
    end

    assign IO_RDATA = st.out.rdata;
    assign ISA_CLK_SEL = st.out.clk_sel;
    assign CMOS_UPPER_EN = st.out.cmos_upper_en;
    assign FLASH_WRITE_OK = st.out.flash_ok;
    assign REC16_CLKS = st.out.rec16;
    assign REC8_CLKS = st.out.rec8;
    assign WAIT16_ZERO = st.out.wait16_zero;
    assign PCI_BUF_HIGH = st.out.buf_high;
    assign TRIG_MODE_HIGH = st.out.trig;
    assign SYS_WAKE = st.out.sys_wake;
    assign MON_WAKE = st.out.mon_wake;

endmodule : icfg_bank

//--- rtl/icfg_pkg.sv
// constants and types of the isa index configuration bank
// Operation
// - Software writes a configuration index to I/O config_index_port; device latches it.
// - Data config_data_port reads and writes the register chosen by the latched index.
// - Reading config_index_port returns the last index written.
// - Trigger irq_trigger_mode_high: IRQ9-12,14,15 bits; 0 edge, 1 level.
// - IRQ8 and IRQ13 trigger bits are written 0 and always read 0.
// - Reset clears the trigger register, all interrupts edge sensitive.
// - ISA clock select: 00 7.159MHz, 01 host clock/4, 10 host clock/3.
// - Enable bit permits access to upper 128 CMOS bytes; 0 blocks it.
// - Flash permitted when lock is 0 or override is 1.
// - 16-bit I/O recovery: 00 five, 01 four, 10 three, 11 two cycles.
// - 8-bit I/O recovery: 00 eight, 01 five, 10 four, 11 three cycles.
// - 16-bit memory and I/O wait bit: 0 one wait state, 1 none.
// - Eight-bit scratch register, freely written and read, no side effect.
// - Mirror register returns last value written to CMOS index port 70h.
// - Cleared system-standby IRQ1-15 mask bit lets that IRQ end system standby; here IRQ2 has no such mask bit and never does.
// - Cleared pin mask bit lets general pin activity end system standby.
// - Cleared NMI system-standby mask bit lets NMI end system standby.
// - Cleared monitor-standby IRQ1-15 mask bit lets that IRQ end monitor standby.
// - Cleared NMI monitor-standby mask bit lets NMI end monitor standby.
package icfg_pkg;

    localparam logic [15:0] IDX_PORT = 16'h0022;
    localparam logic [15:0] DATA_PORT = 16'h0023;
    localparam logic [15:0] CMOS_PORT = 16'h0070;
    localparam logic [15:0] TRIG_PORT = 16'h04d1;

    localparam logic [7:0] IDX_CLK_FLASH = 8'h50;
    localparam logic [7:0] IDX_RECOVERY = 8'h51;
    localparam logic [7:0] IDX_BUF_CUR = 8'h53;
    localparam logic [7:0] IDX_SCRATCH = 8'h54;
    localparam logic [7:0] IDX_CMOS_MIRROR = 8'h55;
    localparam logic [7:0] IDX_SYS_LO = 8'h58;
    localparam logic [7:0] IDX_SYS_HI = 8'h59;
    localparam logic [7:0] IDX_MON_LO = 8'h5a;
    localparam logic [7:0] IDX_MON_HI = 8'h5b;

    // writable bits of each register; the rest read as zero
    localparam logic [7:0] WMASK_CLK_FLASH = 8'hed;
    localparam logic [7:0] WMASK_RECOVERY = 8'hf4;
    localparam logic [7:0] WMASK_BUF_CUR = 8'h01;
    localparam logic [7:0] WMASK_TRIG = 8'hde;

    localparam int CLK_SEL_LSB = 6;
    localparam int FLASH_LOCK_BIT = 5;
    localparam int CMOS_UPPER_BIT = 3;
    localparam int FLASH_OVR_BIT = 2;
    localparam int REC16_LSB = 6;
    localparam int REC8_LSB = 4;
    localparam int WAIT16_BIT = 2;
    localparam int BUF_CUR_BIT = 0;

    localparam logic [7:0] RST_INDEX = 8'h00;
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [7:0] RST_TRIG = 8'h00;

    localparam logic [1:0] CLK_SEL_OSC = 2'h0;
    localparam logic [1:0] CLK_SEL_DIV4 = 2'h1;
    localparam logic [1:0] CLK_SEL_DIV3 = 2'h2;

    localparam logic [3:0] REC16_CODE0 = 4'h5;
    localparam logic [3:0] REC16_CODE1 = 4'h4;
    localparam logic [3:0] REC16_CODE2 = 4'h3;
    localparam logic [3:0] REC16_CODE3 = 4'h2;
    localparam logic [3:0] REC8_CODE0 = 4'h8;
    localparam logic [3:0] REC8_CODE1 = 4'h5;
    localparam logic [3:0] REC8_CODE2 = 4'h4;
    localparam logic [3:0] REC8_CODE3 = 4'h3;

    // wake sources: bit 0 nmi, bit 1 general pin, bits 16:2 irq 15:1
    localparam int SRC_W = 17;

    typedef struct packed {
        logic [1:0] clk_sel;
        logic cmos_upper_en;
        logic flash_ok;
        logic [3:0] rec16;
        logic [3:0] rec8;
        logic wait16_zero;
        logic buf_high;
        logic [7:0] trig;
        logic [7:0] rdata;
        logic sys_wake;
        logic mon_wake;
    } icfg_out_type;

    typedef struct packed {
        logic [7:0] index;
        logic [7:0] clk_flash;
        logic [7:0] recovery;
        logic [7:0] buf_cur;
        logic [7:0] scratch;
        logic [7:0] cmos_mirror;
        logic [7:0] sys_lo;
        logic [7:0] sys_hi;
        logic [7:0] mon_lo;
        logic [7:0] mon_hi;
        logic [SRC_W-1:0] sync1;
        logic [SRC_W-1:0] sync2;
        logic [SRC_W-1:0] sync3;
        logic [SRC_W-1:0] stable;
        icfg_out_type out;
    } icfg_state_type;

endpackage : icfg_pkg

//--- testbench/icfg_wake_src.sv
// wake source model: raises one interrupt, nmi or pin line per request
`timescale 1ns/10ps
module icfg_wake_src (
    input wire logic CLK,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [4:0] src,
    output logic [15:1] irq,
    output logic nmi,
    output logic pin
);
    logic [16:0] lines;
    logic [2:0] hold;
    // lines are held well past the two-cycle glitch filter
    always_ff @(posedge CLK) begin
        if (!rst_n) begin
            lines <= 17'h0;
            hold <= 3'h0;
        end else if (go) begin
            lines <= 17'h1 << src;
            hold <= 3'h4;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end else begin
            lines <= 17'h0;
        end
    end
    assign nmi = lines[0];
    assign pin = lines[1];
    assign irq = lines[16:2];
endmodule : icfg_wake_src

//--- testbench/icfg_bank_checker.sv
// assertion checker for the isa configuration bank
`timescale 1ns/10ps
module icfg_bank_checker (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [15:0] IO_ADDR,
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic [7:0] IO_WDATA,
    input wire logic [7:0] IO_RDATA,
    input wire logic SYS_STANDBY,
    input wire logic FLASH_WRITE_OK,
    input wire logic [1:0] ISA_CLK_SEL,
    input wire logic [7:0] TRIG_MODE_HIGH,
    input wire logic SYS_WAKE
);
    logic [7:0] idx;
    logic cfg_wr;
    assign cfg_wr = IO_WR && IO_ADDR == 16'h0023 && idx == 8'h50;
    always_ff @(posedge CLK) begin
        if (!RESET_N) idx <= 8'h00;
        else if (IO_WR && IO_ADDR == 16'h0022) idx <= IO_WDATA;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    a_rdata_idle_zero: assert property (
        !$past(IO_RD) |-> IO_RDATA == 8'h00)
        else $error("rdata not zero");
    a_index_read_back: assert property (
        IO_RD && IO_ADDR == 16'h0022 |=> IO_RDATA == $past(idx))
        else $error("index readback");
    a_trig_write: assert property (
        IO_WR && IO_ADDR == 16'h04d1
        |=> TRIG_MODE_HIGH == ($past(IO_WDATA) & 8'hde))
        else $error("trigger write");
    a_trig_reserved_zero: assert property (
        TRIG_MODE_HIGH[5] == 1'b0 && TRIG_MODE_HIGH[0] == 1'b0)
        else $error("trigger reserved");
    a_trig_reset: assert property (
        $rose(RESET_N) |-> TRIG_MODE_HIGH == 8'h00)
        else $error("trigger reset");
    a_clk_sel_write: assert property (
        cfg_wr |=> ISA_CLK_SEL == $past(IO_WDATA[7:6]))
        else $error("clock select");
    a_flash_ok: assert property (
        cfg_wr |=> FLASH_WRITE_OK
            == (!$past(IO_WDATA[5]) || $past(IO_WDATA[2])))
        else $error("flash ok");
    a_wake_one_cycle: assert property (SYS_WAKE |=> !SYS_WAKE)
        else $error("wake pulse width");
    a_wake_in_standby: assert property (SYS_WAKE |-> $past(SYS_STANDBY))
        else $error("wake outside standby");
endmodule : icfg_bank_checker
bind icfg_bank icfg_bank_checker chk (.CLK(CLK), .RESET_N(RESET_N),
    .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_WDATA(IO_WDATA),
    .IO_RDATA(IO_RDATA), .SYS_STANDBY(SYS_STANDBY),
    .FLASH_WRITE_OK(FLASH_WRITE_OK), .ISA_CLK_SEL(ISA_CLK_SEL),
    .TRIG_MODE_HIGH(TRIG_MODE_HIGH), .SYS_WAKE(SYS_WAKE));

//--- testbench/icfg_bank_tb_top.sv
// testbench for the isa configuration bank
`timescale 1ns/10ps
module icfg_bank_tb_top;
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic [15:0] IO_ADDR = 16'h0;
    logic IO_WR = 1'b0;
    logic IO_RD = 1'b0;
    logic [7:0] IO_WDATA = 8'h0;
    logic SYS_STANDBY = 1'b0;
    logic MON_STANDBY = 1'b0;
    logic go = 1'b0;
    logic [4:0] src = 5'h0;
    logic [15:1] IRQ_IN;
    logic NMI_IN, GENERAL_PIN_ZERO, CMOS_UPPER_EN, FLASH_WRITE_OK, WAIT16_ZERO;
    logic PCI_BUF_HIGH, SYS_WAKE, MON_WAKE;
    logic [1:0] ISA_CLK_SEL;
    logic [3:0] REC16_CLKS, REC8_CLKS;
    logic [7:0] IO_RDATA, TRIG_MODE_HIGH;
    int n_errors = 0;
    int num_checks = 0;
    always #5 CLK = ~CLK;
    icfg_bank dut (.CLK(CLK), .RESET_N(RESET_N), .IO_ADDR(IO_ADDR),
        .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA),
        .IRQ_IN(IRQ_IN), .NMI_IN(NMI_IN), .GENERAL_PIN_ZERO(GENERAL_PIN_ZERO),
        .SYS_STANDBY(SYS_STANDBY), .MON_STANDBY(MON_STANDBY),
        .ISA_CLK_SEL(ISA_CLK_SEL), .CMOS_UPPER_EN(CMOS_UPPER_EN),
        .FLASH_WRITE_OK(FLASH_WRITE_OK), .REC16_CLKS(REC16_CLKS),
        .REC8_CLKS(REC8_CLKS), .WAIT16_ZERO(WAIT16_ZERO),
        .PCI_BUF_HIGH(PCI_BUF_HIGH), .TRIG_MODE_HIGH(TRIG_MODE_HIGH),
        .SYS_WAKE(SYS_WAKE), .MON_WAKE(MON_WAKE));
    icfg_wake_src model (.CLK(CLK), .rst_n(RESET_N), .go(go), .src(src),
        .irq(IRQ_IN), .nmi(NMI_IN), .pin(GENERAL_PIN_ZERO));
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(negedge CLK);
        IO_ADDR = a;
        IO_WDATA = d;
        IO_WR = 1'b1;
        @(negedge CLK);
        IO_WR = 1'b0;
    endtask : wr
    task automatic rd(logic [15:0] a, logic [7:0] exp);
        @(negedge CLK);
        IO_ADDR = a;
        IO_RD = 1'b1;
        @(negedge CLK);
        IO_RD = 1'b0;
        chk("rdata", exp, IO_RDATA);
    endtask : rd
    task automatic cfg(logic [7:0] i, logic [7:0] d);
        wr(16'h0022, i);
        wr(16'h0023, d);
    endtask : cfg
    // fire one wake source and count pulses on both wake outputs
    task automatic wake(logic [4:0] s, logic es, logic em);
        int ns;
        int nm;
        ns = 0;
        nm = 0;
        @(negedge CLK);
        src = s;
        go = 1'b1;
        @(negedge CLK);
        go = 1'b0;
        repeat (10) begin
            @(negedge CLK);
            ns += int'(SYS_WAKE === 1'b1);
            nm += int'(MON_WAKE === 1'b1);
        end
        chk("sys wakes", {7'h0, es}, 8'(ns));
        chk("mon wakes", {7'h0, em}, 8'(nm));
    endtask : wake
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (8) @(negedge CLK);
        RESET_N = 1'b1;
        chk("trig", 8'h00, TRIG_MODE_HIGH);
        rd(16'h04d1, 8'h00);
        cfg(8'h54, 8'ha5);
        rd(16'h0022, 8'h54);
        wr(16'h0022, 8'h59);
        rd(16'h0023, 8'h00);
        wr(16'h0022, 8'h54);
        rd(16'h0023, 8'ha5);
        wr(16'h04d1, 8'hde);
        rd(16'h04d1, 8'hde);
        $display("test ports done");
        // second reset in mid-run must clear the trigger register again
        RESET_N = 1'b0;
        repeat (2) @(negedge CLK);
        RESET_N = 1'b1;
        chk("trig", 8'h00, TRIG_MODE_HIGH);
        rd(16'h04d1, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            cfg(8'h50, {i[1:0], i[0], 1'b0, i[0], i[1], 2'h0});
            chk("clksel", 8'(i), {6'h0, ISA_CLK_SEL});
            chk("flash", {7'h0, !i[0] | i[1]}, {7'h0, FLASH_WRITE_OK});
            chk("cmos", {7'h0, i[0]}, {7'h0, CMOS_UPPER_EN});
            cfg(8'h51, {i[1:0], i[1:0], 1'b0, i[0], 2'h0});
            chk("rec16", 8'(5 - i), {4'h0, REC16_CLKS});
            chk("rec8", i == 0 ? 8'h08 : 8'(6 - i), {4'h0, REC8_CLKS});
            chk("wait16", {7'h0, i[0]}, {7'h0, WAIT16_ZERO});
        end
        cfg(8'h51, 8'hff);
        rd(16'h0023, 8'hf4);
        wr(16'h0070, 8'h8e);
        cfg(8'h55, 8'h00);
        rd(16'h0023, 8'h8e);
        cfg(8'h53, 8'hff);
        chk("bufhigh", 8'h01, {7'h0, PCI_BUF_HIGH});
        rd(16'h0023, 8'h01);
        $display("test fields done");
        SYS_STANDBY = 1'b1;
        MON_STANDBY = 1'b1;
        wake(5'd4, 1'b1, 1'b1);
        wake(5'd0, 1'b1, 1'b1);
        wake(5'd1, 1'b1, 1'b0);
        wake(5'd11, 1'b1, 1'b1);
        cfg(8'h58, 8'hff);
        cfg(8'h59, 8'hff);
        wake(5'd4, 1'b0, 1'b1);
        wake(5'd0, 1'b0, 1'b1);
        wake(5'd1, 1'b0, 1'b0);
        cfg(8'h5a, 8'hff);
        cfg(8'h5b, 8'hff);
        wake(5'd0, 1'b0, 1'b0);
        wake(5'd11, 1'b0, 1'b0);
        cfg(8'h58, 8'h00);
        SYS_STANDBY = 1'b0;
        cfg(8'h5a, 8'h00);
        cfg(8'h5b, 8'h00);
        MON_STANDBY = 1'b0;
        wake(5'd4, 1'b0, 1'b0);
        $display("test wake done");
        final_report();
    end
endmodule : icfg_bank_tb_top
